/* File: hdl/acs_pkg.sv */
// Shared constants for the conversion sequencer: register map, fields, reset values, timing.
package acs_pkg;

  // ----------------------------------------------------------------
  // Clock and sampling-rate timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ      = 25_000_000;
  localparam int unsigned FIX_RATE_HZ = 8_000;
  localparam int unsigned FIX_DIV     = CLK_HZ / FIX_RATE_HZ;
  localparam int unsigned DIV_CODE0   = 4;
  localparam int unsigned DIV_CODE1   = 8;
  localparam int unsigned DIV_CODE2   = 32;
  localparam int unsigned DIV_W       = 12;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_CFG      = 8'h04;
  localparam logic [7:0] OFS_RES_HIGH = 8'h08;
  localparam logic [7:0] OFS_RES_LOW  = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_CLR  = 8'h14;
  localparam logic [7:0] OFS_IRQ_EN   = 8'h18;
  localparam logic [7:0] OFS_STATUS   = 8'h1C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_START = 0;
  localparam int unsigned CTRL_CONT  = 1;
  localparam int unsigned CTRL_PWR   = 2;
  localparam int unsigned CFG_OSR    = 0;
  localparam int unsigned CFG_NELC   = 3;
  localparam int unsigned CFG_RATE   = 5;
  localparam int unsigned CFG_CBIAS  = 7;
  localparam int unsigned CFG_ABIAS  = 9;
  localparam int unsigned CFG_W      = 11;
  localparam int unsigned IRQ_DONE   = 0;
  localparam int unsigned IRQ_SAT    = 1;
  localparam int unsigned IRQ_W      = 2;

  // ----------------------------------------------------------------
  // Reset values: full bias on both chains, smallest settings.
  // ----------------------------------------------------------------
  localparam logic [CFG_W-1:0] CFG_RST = 11'h0_780;
  localparam logic [2:0]       CTRL_RST = 3'h0;

  // ----------------------------------------------------------------
  // Datapath sizes
  // ----------------------------------------------------------------
  localparam int unsigned RES_W   = 16;
  localparam int unsigned ACC_W   = 26;
  localparam int unsigned SAMP_W  = 11;
  localparam int unsigned OSR_EXP0 = 3;
  localparam int unsigned TCNT_W  = 14;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_CONV  = 2'b01,
    ST_FINAL = 2'b10
  } acs_state_e;

endpackage : acs_pkg

/* File: hdl/acs_rate_div.sv */
// Sampling-rate divider producing one clock-wide sample tick.
`timescale 1ns/100ps
module acs_rate_div #(
  parameter int unsigned FIX_DIV = acs_pkg::FIX_DIV
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [1:0] sel_i,
  output logic            tick_o
);
  import acs_pkg::*;

  logic [DIV_W-1:0] cnt_q;
  logic [DIV_W-1:0] cnt_d;
  logic [DIV_W-1:0] lim;
  logic             tick_d;

  always_comb begin
    unique case (sel_i)
      2'b00:   lim = DIV_W'(DIV_CODE0 - 1);
      2'b01:   lim = DIV_W'(DIV_CODE1 - 1);
      2'b10:   lim = DIV_W'(DIV_CODE2 - 1);
      default: lim = DIV_W'(FIX_DIV - 1);
    endcase
    // A shorter limit after a code change must not leave the count stranded above it.
    if (cnt_q >= lim) begin
      cnt_d  = '0;
      tick_d = 1'b1;
    end else begin
      cnt_d  = cnt_q + DIV_W'(1);
      tick_d = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q  <= '0;
      tick_o <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_o <= tick_d;
    end
  end

endmodule : acs_rate_div

/* File: hdl/acs_seq.sv */
// Incremental ADC conversion sequencer with Wishbone register file.
//
// Notes on behaviour
// RULE1 - Conversion lasts elementary count times (OSR+1) sample periods, plus one.
// RULE2 - Conversion length spans 10 to 8201 sample periods over the settings grid.
// RULE3 - Continuous mode yields one new result per conversion time.
// RULE4 - Result is a 16-bit two's complement word.
// RULE5 - Out-of-range results clamp to 0x7FFF or 0x8000.
// RULE6 - Below 16 bits, bit under last valid bit is one, lower bits zero.
// RULE7 - Result reads as separate high byte and low byte registers.
// RULE8 - Converter bias field gives quarter to full bias; software limits rate.
// RULE9 - Amplifier bias field uses same encoding, independent of converter bias.
// RULE10 - Amplifiers and converter can be fully switched off when idle.
// RULE11 - Setting start or continuous bit begins a conversion; the code also requires the power bit to be set.
// RULE12 - Oversampling ratio is two to the power three plus field, 8..1024.
// RULE13 - Elementary count is 1, 2, 4 or 8; result is their mean.
// RULE14 - Rate field picks three clock submultiples or a fixed ~8 kHz rate.
// RULE15 - Completion is signalled once the result registers are written.
//
// The placing of the registers and register access over Wishbone are this design's own decisions.
`timescale 1ns/100ps
module acs_seq #(
  parameter int unsigned FIX_DIV = acs_pkg::FIX_DIV
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        mod_bit_i,
  output logic             sample_o,
  output logic             mod_reset_o,
  output logic             chop_o,
  output logic             analog_en_o,
  output logic [1:0]       conv_bias_o,
  output logic [1:0]       amp_bias_o,
  output logic             done_o,
  output logic             irq_o
);
  import acs_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic                acc_hit, wr;
  logic                ack_d;
  logic [31:0]         rdat_d;
  logic [2:0]          ctrl_q, ctrl_d;
  logic [CFG_W-1:0]    cfg_q, cfg_d;
  logic [IRQ_W-1:0]    stat_q, stat_d, ien_q, ien_d, ev;
  logic                irq_d;
  logic                tick, taken;
  acs_state_e          st_q, st_d;
  logic [SAMP_W-1:0]   samp_q, samp_d, osr, wgt;
  logic [2:0]          elem_q, elem_d;
  logic [2:0]          osr_l_q, osr_l_d;
  logic [1:0]          nelc_l_q, nelc_l_d;
  logic [ACC_W-1:0]    acc_q, acc_d;
  logic                chop_d, mrst_d, done_d, sat_d, sat_q;
  logic [RES_W-1:0]    res_q, res_d;
  logic [4:0]          nraw;
  logic signed [31:0]  wide;
  logic [RES_W-1:0]    word, fmask, fbits;
  logic [TCNT_W-1:0]   tcnt_q, tcnt_d, texp;

  // ----------------------------------------------------------------
  // Sample tick
  // ----------------------------------------------------------------
  acs_rate_div #(
    .FIX_DIV (FIX_DIV)
  ) u_div (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .sel_i  (cfg_q[CFG_RATE +: 2]), // RULE14
    .tick_o (tick)
  );

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  always_comb begin
    acc_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wr      = acc_hit & wb_we_i;
    ack_d   = acc_hit;
    ctrl_d  = ctrl_q;
    cfg_d   = cfg_q;
    ien_d   = ien_q;
    // A start that the sequencer takes is consumed; a new write re-arms it.
    if (taken) begin
      ctrl_d[CTRL_START] = 1'b0;
    end
    if (wr && wb_sel_i[0] && wb_adr_i == OFS_CTRL) begin
      ctrl_d = wb_dat_i[2:0];
    end
    if (wr && wb_adr_i == OFS_CFG) begin
      if (wb_sel_i[0]) begin
        cfg_d[7:0] = wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        cfg_d[CFG_W-1:8] = wb_dat_i[CFG_W-1:8];
      end
    end
    if (wr && wb_sel_i[0] && wb_adr_i == OFS_IRQ_EN) begin
      ien_d = wb_dat_i[IRQ_W-1:0];
    end
    stat_d = stat_q;
    if (wr && wb_sel_i[0] && wb_adr_i == OFS_IRQ_CLR) begin
      stat_d = stat_q & ~wb_dat_i[IRQ_W-1:0];
    end
    // Set beats clear so an event in the clearing cycle survives.
    stat_d = stat_d | ev;
    irq_d  = |(stat_q & ien_q);
    rdat_d = '0;
    if (acc_hit && !wb_we_i) begin
      unique case (wb_adr_i)
        OFS_CTRL:     rdat_d[2:0]       = ctrl_q;
        OFS_CFG:      rdat_d[CFG_W-1:0] = cfg_q;
        OFS_RES_HIGH: rdat_d[7:0]       = res_q[15:8]; // RULE7
        OFS_RES_LOW:  rdat_d[7:0]       = res_q[7:0]; // RULE7
        OFS_IRQ_STAT: rdat_d[IRQ_W-1:0] = stat_q;
        OFS_IRQ_EN:   rdat_d[IRQ_W-1:0] = ien_q;
        OFS_STATUS:   rdat_d[0]         = (st_q != ST_IDLE);
        default:      rdat_d            = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o    <= 1'b0;
      wb_dat_o    <= '0;
      ctrl_q      <= CTRL_RST;
      cfg_q       <= CFG_RST;
      stat_q      <= '0;
      ien_q       <= '0;
      irq_o       <= 1'b0;
      conv_bias_o <= CFG_RST[CFG_CBIAS +: 2];
      amp_bias_o  <= CFG_RST[CFG_ABIAS +: 2];
      analog_en_o <= 1'b0;
    end else begin
      wb_ack_o    <= ack_d;
      wb_dat_o    <= rdat_d;
      ctrl_q      <= ctrl_d;
      cfg_q       <= cfg_d;
      stat_q      <= stat_d;
      ien_q       <= ien_d;
      irq_o       <= irq_d;
      conv_bias_o <= cfg_q[CFG_CBIAS +: 2]; // RULE8
      amp_bias_o  <= cfg_q[CFG_ABIAS +: 2]; // RULE9
      analog_en_o <= ctrl_q[CTRL_PWR]; // RULE10
    end
  end

  // ----------------------------------------------------------------
  // Result formatting
  // ----------------------------------------------------------------
  always_comb begin
    // The exponent needs four bits: settings above four would wrap a three-bit sum.
    osr   = SAMP_W'(1) << (4'(osr_l_q) + 4'(OSR_EXP0)); // RULE12
    wgt   = osr - samp_q;
    nraw  = 5'(2 * (osr_l_q + OSR_EXP0)) + 5'(nelc_l_q);
    // Summing rather than averaging only scales by the count, which the shift absorbs.
    if (nraw <= 5'(RES_W)) begin // RULE13
      wide = 32'($signed(acc_d)) <<< (5'(RES_W) - nraw);
    end else begin
      wide = 32'($signed(acc_d)) >>> (nraw - 5'(RES_W));
    end
    sat_d = 1'b0;
    if (wide > 32'sh0000_7FFF) begin // RULE5
      word  = 16'h7FFF;
      sat_d = 1'b1;
    end else if (wide < -32'sh0000_8000) begin // RULE5
      word  = 16'h8000;
      sat_d = 1'b1;
    end else begin
      word = wide[RES_W-1:0]; // RULE4
    end
    fmask = '0;
    fbits = '0;
    if (nraw < 5'(RES_W)) begin // RULE6
      fmask = (16'h0001 << (5'(RES_W) - nraw)) - 16'h0001;
      fbits = 16'h0001 << (5'(RES_W - 1) - nraw);
    end
  end

  // ----------------------------------------------------------------
  // Conversion sequence
  // ----------------------------------------------------------------
  always_comb begin
    st_d     = st_q;
    samp_d   = samp_q;
    elem_d   = elem_q;
    acc_d    = acc_q;
    osr_l_d  = osr_l_q;
    nelc_l_d = nelc_l_q;
    chop_d   = chop_o;
    mrst_d   = mod_reset_o;
    res_d    = res_q;
    done_d   = 1'b0;
    taken    = 1'b0;
    tcnt_d   = tcnt_q;
    if (tick && st_q == ST_CONV && samp_q != osr) begin
      // Chopped periods see the input inverted, so the sign flips back here.
      if (mod_bit_i ^ chop_o) begin
        acc_d = acc_q + ACC_W'(wgt);
      end else begin
        acc_d = acc_q - ACC_W'(wgt);
      end
    end
    unique case (st_q)
      ST_IDLE: begin
        // Without power the analog side cannot convert, so requests wait.
        if ((ctrl_q[CTRL_START] || ctrl_q[CTRL_CONT]) && ctrl_q[CTRL_PWR]) begin // RULE11
          st_d     = ST_CONV;
          taken    = 1'b1;
          samp_d   = '0;
          elem_d   = '0;
          acc_d    = '0;
          chop_d   = 1'b0;
          mrst_d   = 1'b0;
          tcnt_d   = '0;
          osr_l_d  = cfg_q[CFG_OSR +: 3];
          nelc_l_d = cfg_q[CFG_NELC +: 2];
        end
      end
      ST_CONV: begin
        if (tick) begin
          tcnt_d = tcnt_q + TCNT_W'(1);
          if (samp_q == osr) begin // RULE1
            samp_d = '0;
            mrst_d = 1'b0;
            chop_d = ~chop_o;
            elem_d = elem_q + 3'd1;
            if (elem_q == 3'((4'd1 << nelc_l_q) - 4'd1)) begin // RULE13
              st_d = ST_FINAL;
            end
          end else begin
            samp_d = samp_q + SAMP_W'(1);
            mrst_d = (samp_d == osr);
          end
        end
      end
      ST_FINAL: begin
        if (tick) begin // RULE1
          tcnt_d = tcnt_q + TCNT_W'(1);
          res_d  = (word & ~fmask) | fbits; // RULE6
          done_d = 1'b1; // RULE15
          st_d   = ST_IDLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
    if (!ctrl_q[CTRL_PWR]) begin
      st_d   = ST_IDLE;
      mrst_d = 1'b0;
    end
  end

  assign ev = {sat_d & done_d, done_d}; // RULE15

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q        <= ST_IDLE;
      samp_q      <= '0;
      elem_q      <= '0;
      acc_q       <= '0;
      osr_l_q     <= '0;
      nelc_l_q    <= '0;
      chop_o      <= 1'b0;
      mod_reset_o <= 1'b0;
      res_q       <= '0;
      done_o      <= 1'b0;
      sample_o    <= 1'b0;
      tcnt_q      <= '0;
      sat_q       <= 1'b0;
    end else begin
      st_q        <= st_d;
      samp_q      <= samp_d;
      elem_q      <= elem_d;
      acc_q       <= acc_d;
      osr_l_q     <= osr_l_d;
      nelc_l_q    <= nelc_l_d;
      chop_o      <= chop_d;
      mod_reset_o <= mrst_d;
      res_q       <= res_d;
      done_o      <= done_d;
      sample_o    <= tick && st_q == ST_CONV;
      tcnt_q      <= tcnt_d;
      sat_q       <= sat_d & done_d;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  assign texp = TCNT_W'(((SAMP_W + 4)'(osr) + 15'd1) << nelc_l_q) + TCNT_W'(1);

  a_conv_length: assert property (done_o |-> tcnt_q == texp) // RULE1
    else $error("conversion length differs from N*(OSR+1)+1");
  a_len_range: assert property (done_o |-> tcnt_q >= 14'd10 && tcnt_q <= 14'd8201) // RULE2
    else $error("conversion length outside 10..8201");
  a_cont_next: assert property (done_o && ctrl_q[CTRL_CONT] && ctrl_q[CTRL_PWR] // RULE3
                                |=> st_q == ST_CONV)
    else $error("continuous mode did not restart");
  a_sat_code: assert property (sat_q |-> res_q[15:14] == 2'b01 || res_q[15:14] == 2'b10) // RULE5
    else $error("saturated result is not a full-scale code");
  a_force_low: assert property (done_o && nraw == 5'd6 |-> res_q[9:0] == 10'h200) // RULE6
    else $error("forced low bits wrong at smallest setting");
  a_high_byte: assert property (acc_hit && !wb_we_i && wb_adr_i == OFS_RES_HIGH // RULE7
                                |=> wb_ack_o && wb_dat_o == {24'h0, $past(res_q[15:8])})
    else $error("high result byte read wrong");
  a_bias_follow: assert property (##1 $changed(cfg_q) |-> ##1 // RULE8
                                  conv_bias_o == $past(cfg_q[CFG_CBIAS +: 2]) &&
                                  amp_bias_o == $past(cfg_q[CFG_ABIAS +: 2]))
    else $error("bias outputs do not follow configuration");
  a_power_off: assert property (!ctrl_q[CTRL_PWR] |=> st_q == ST_IDLE && !analog_en_o) // RULE10
    else $error("conversion runs while powered down");
  a_start_go: assert property (st_q == ST_IDLE && ctrl_q[CTRL_START] && ctrl_q[CTRL_PWR] // RULE11
                               |=> st_q == ST_CONV)
    else $error("start did not begin a conversion");
  a_done_flag: assert property (done_o |-> stat_q[IRQ_DONE]) // RULE15
    else $error("completion flag not set with result");

  c_done: cover property (done_o);
  c_cont: cover property (done_o && ctrl_q[CTRL_CONT] ##[1:1000] done_o);
  c_sat: cover property (sat_q);
  c_irq: cover property (irq_o ##1 !irq_o);

endmodule : acs_seq

/* File: dv/acs_mod_model.sv */
// Behavioural model of the modulator and amplifier chain behind the sequencer.
`timescale 1ns/100ps
module acs_mod_model (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic level_i,
  input  wire logic chop_i,
  input  wire logic mod_reset_i,
  input  wire logic analog_en_i,
  output logic      mod_bit_o
);
  logic junk_q;

  // ----------------------------------------------------------------
  // Output bit
  // ----------------------------------------------------------------
  // An unpowered or resetting stage gives no valid bit, so it toggles to expose misuse.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      junk_q <= 1'b0;
    end else begin
      junk_q <= ~junk_q;
    end
  end

  // A full-scale input is seen through the current chopping polarity.
  assign mod_bit_o = (analog_en_i && !mod_reset_i) ? (level_i ^ chop_i) : junk_q;
endmodule : acs_mod_model

/* File: dv/tb.sv */
// Self-checking testbench for the conversion sequencer.
`timescale 1ns/100ps
module tb;
  import acs_pkg::*;
  localparam int unsigned SIM_DIV = 16;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [3:0]  wb_sel_i = 4'h0;
  logic        wb_we_i = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        level = 1'b0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o, mod_bit_i, sample_o, mod_reset_o, chop_o, analog_en_o, done_o, irq_o;
  logic [1:0]  conv_bias_o, amp_bias_o;
  logic [31:0] exp_rd[$];
  int          exp_per[$];
  int          exp_smp[$];
  int          err_total = 0, cmp_count = 0, seed = 32'h239e;
  int          done_cnt = 0, cyc_cnt = 0, last_done = 0, per, smp_cnt = 0;

  acs_seq #(.FIX_DIV(SIM_DIV)) u_acs_seq (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mod_bit_i(mod_bit_i),
    .sample_o(sample_o), .mod_reset_o(mod_reset_o), .chop_o(chop_o), .analog_en_o(analog_en_o),
    .conv_bias_o(conv_bias_o), .amp_bias_o(amp_bias_o), .done_o(done_o), .irq_o(irq_o));
  acs_mod_model u_acs_mod_model (.clk_i(clk_i), .rst_i(rst_i), .level_i(level), .chop_i(chop_o),
    .mod_reset_i(mod_reset_o), .analog_en_i(analog_en_o), .mod_bit_o(mod_bit_i));

  always #20 clk_i = ~clk_i;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("comparisons=%0d mismatches=%0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= 4'hF;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) err_total++;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask : wb

  task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
    exp_rd.push_back(exp);
    wb(1'b0, adr, 32'h0000_0000);
  endtask : rd

  task automatic wait_done(input int target);
    int n;
    n = 0;
    while (done_cnt < target && n < 40000) begin
      @(posedge clk_i);
      n++;
    end
    if (done_cnt < target) err_total++;
  endtask : wait_done

  // Saturated full-scale code with the unused low bits forced.
  function automatic logic [15:0] res(input int o, input int e, input logic p);
    int n;
    logic [15:0] v;
    n = 2 * (o + 3) + e;
    v = p ? 16'h7FFF : 16'h8000;
    if (n < 16) begin
      v = v & ~((16'h0001 << (16 - n)) - 16'h0001);
      v = v | (16'h0001 << (15 - n));
    end
    return v;
  endfunction : res

  // ----------------------------------------------------------------
  // Monitor: read data at ack, conversion period at each completion
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (wb_ack_o === 1'b1 && wb_cyc_i && !wb_we_i) begin
      if (exp_rd.size() > 0) chk(wb_dat_o, exp_rd.pop_front());
      else err_total++;
    end
    if (sample_o === 1'b1) smp_cnt++;
    if (done_o === 1'b1) begin
      done_cnt++;
      if (exp_per.size() > 0) begin
        per = exp_per.pop_front();
        if (per != 0) chk(cyc_cnt - last_done, per);
      end
      if (exp_smp.size() > 0) begin
        per = exp_smp.pop_front();
        if (per != 0) chk(smp_cnt, per);
      end
      smp_cnt = 0;
      last_done = cyc_cnt;
    end
  end

  initial begin
    repeat (90000) @(posedge clk_i);
    err_total++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int t, div, r, base;
    logic [2:0] osr;
    logic [1:0] nl, rate;
    logic [15:0] e;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(OFS_CFG, {21'h0, CFG_RST});
    rd(OFS_CTRL, 32'h0);
    rd(OFS_RES_HIGH, 32'h0);
    rd(OFS_RES_LOW, 32'h0);
    wb(1'b1, OFS_IRQ_STAT, 32'h3);
    rd(OFS_IRQ_STAT, 32'h0);
    rd(8'h24, 32'h0);
    chk({31'h0, analog_en_o}, 32'h0);
    for (int b = 0; b < 4; b++) begin
      wb(1'b1, OFS_CFG, 32'((b << CFG_CBIAS) | ((3 - b) << CFG_ABIAS)));
      @(posedge clk_i);
      chk({30'h0, conv_bias_o}, 32'(b));
      chk({30'h0, amp_bias_o}, 32'(3 - b));
    end
    level <= 1'b1;
    wb(1'b1, OFS_IRQ_EN, 32'h1);
    wb(1'b1, OFS_CFG, 32'h0);
    t = done_cnt;
    wb(1'b1, OFS_CTRL, 32'h1);
    repeat (200) @(posedge clk_i);
    chk(done_cnt, t);
    wb(1'b1, OFS_CTRL, 32'h5);
    wait_done(t + 1);
    chk({31'h0, analog_en_o}, 32'h1);
    repeat (3) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h1);
    rd(OFS_RES_HIGH, 32'h7E);
    rd(OFS_RES_LOW, 32'h00);
    rd(OFS_IRQ_STAT, 32'h3);
    repeat (200) @(posedge clk_i);
    chk(done_cnt, t + 1);
    wb(1'b1, OFS_IRQ_EN, 32'h0);
    repeat (3) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h0);
    wb(1'b1, OFS_IRQ_CLR, 32'h3);
    rd(OFS_IRQ_STAT, 32'h0);
    wb(1'b1, OFS_IRQ_EN, 32'h1);
    rd(OFS_IRQ_EN, 32'h1);
    repeat (3) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h0);
    // Slow rates only at small settings keep the whole grid inside the run budget.
    for (int c = 0; c < 18; c++) begin
      osr = (c < 16) ? 3'(c / 4) : ((c == 16) ? 3'd5 : 3'd4);
      nl = (c < 16) ? 2'(c % 4) : ((c == 16) ? 2'd1 : 2'd3);
      r = $random(seed);
      rate = (c >= 16) ? 2'd0 : ((osr < 2) ? r[1:0] : {1'b0, r[0]});
      level <= r[2];
      div = (rate == 0) ? DIV_CODE0 : (rate == 1) ? DIV_CODE1 : (rate == 2) ? DIV_CODE2 : SIM_DIV;
      t = (1 << nl) * ((8 << osr) + 1) + 1;
      e = res(osr, nl, r[2]);
      wb(1'b1, OFS_CFG, {21'h0, 2'b11, r[4:3], rate, nl, osr});
      exp_per.push_back(0);
      exp_per.push_back(t * div);
      exp_smp.push_back(0);
      exp_smp.push_back((1 << nl) * ((8 << osr) + 1));
      base = done_cnt;
      wb(1'b1, OFS_CTRL, 32'h6);
      wait_done(base + 2);
      rd(OFS_STATUS, 32'h1);
      wb(1'b1, OFS_CTRL, 32'h0);
      rd(OFS_RES_HIGH, {24'h0, e[15:8]});
      rd(OFS_RES_LOW, {24'h0, e[7:0]});
    end
    repeat (4) @(posedge clk_i);
    complete_run();
  end
endmodule : tb
